// file: alu_pkg.sv
package alu_pkg;

    localparam int ACC_W = 32;
    localparam int WORD_W = 16;
    localparam int STACK_DEPTH = 8;
    localparam int CNT_W = 6;
    localparam int BIT_CNT_MIN = 1;
    localparam int BIT_CNT_MAX = 32;
    localparam logic [31:0] ACC_RESET = 32'h0000_0000;
    localparam int MSB_POS = 31;

    typedef enum logic [3:0] {
        OP_NOP          = 4'h0,
        OP_AND_WORD     = 4'h1,
        OP_OR_WORD      = 4'h2,
        OP_XOR_WORD     = 4'h3,
        OP_AND_DOUBLE   = 4'h4,
        OP_OR_DOUBLE    = 4'h5,
        OP_XOR_DOUBLE   = 4'h6,
        OP_AND_BITFIELD = 4'h7,
        OP_OR_BITFIELD  = 4'h8,
        OP_XOR_BITFIELD = 4'h9,
        OP_AND_STACK    = 4'hA,
        OP_OR_STACK     = 4'hB,
        OP_XOR_STACK    = 4'hC,
        OP_LOAD_WORD    = 4'hD
    } opcode_t;

    typedef enum logic [1:0] {
        FN_AND = 2'h0,
        FN_OR  = 2'h1,
        FN_XOR = 2'h2
    } logic_fn_t;

    typedef struct packed {
        opcode_t opcode;
        logic [31:0] operand;
        logic [5:0] bit_count;
    } alu_req_t;

    typedef struct packed {
        logic [31:0] acc;
        logic zero_result_flag;
        logic negative_result_flag;
    } alu_status_t;

endpackage

// file: bitfield_packer.sv
`timescale 1ns/1ps
module bitfield_packer (
    // Gathered discrete bits and run length.
    input wire logic [31:0] bits_i,
    input wire logic [5:0] count_i,
    // Packed operand.
    output logic [31:0] packed_o
);
    logic [31:0] keep_mask;

    genvar g;
    generate
        for (g = 0; g < alu_pkg::ACC_W; g++) begin : g_mask
            assign keep_mask[g] = (32'(g) < 32'(count_i));
        end
    endgenerate

    // Start address sits in bit 0; bits beyond the run read as zero.
    assign packed_o = bits_i & keep_mask;
endmodule // bitfield_packer

// file: accumulator_logic_unit.sv
`timescale 1ns/1ps
// Summary of operation
// - Word OR: low 16 bits with word.
// - Word XOR: low 16 bits with word.
// - Double AND: 32 bits with operand.
// - Double OR: 32 bits with operand.
// - Double XOR: 32 bits with operand.
// - Bit-field AND with 1 to 32 bits.
// - Bit-field OR with 1 to 32 bits.
// - Stack AND with top stack entry.
// - Stack OR with top stack entry.
// - Stack operations pop and shift stack up.
// - Zero flag set when result is zero.
// - Negative flag follows result bit 31.
// - Flags hold until next affecting instruction.
// - Load after load pushes old accumulator.
module accumulator_logic_unit (
    // Clock and reset.
    input wire logic SYS_CLK_I,
    input wire logic RST_I,
    // Instruction from the sequencer.
    input wire logic OP_VALID_I,
    input wire alu_pkg::alu_req_t REQ_I,
    // Accumulator and flags, stack top, ready and done.
    output alu_pkg::alu_status_t STATUS_O,
    output logic [31:0] STACK_TOP_O,
    output logic OP_READY_O,
    output logic OP_DONE_O
);
    ////////////////////////////////////////////////////////////////////////////
    logic [31:0] acc_q, acc_d;
    logic zero_q, zero_d;
    logic neg_q, neg_d;
    logic done_q;
    logic last_was_load_q, last_was_load_d;
    logic [31:0] stack_q [alu_pkg::STACK_DEPTH];
    logic [31:0] field_operand;
    logic [31:0] operand;
    logic [31:0] result;
    logic affects_flags;
    logic do_pop;
    logic do_push;
    logic is_word;
    logic is_bitfield;
    logic is_stack;
    logic is_load;
    logic count_ok;
    alu_pkg::logic_fn_t fn;
    alu_pkg::opcode_t op;

    function automatic alu_pkg::logic_fn_t decode_fn(input alu_pkg::opcode_t o);
        unique case (o)
            alu_pkg::OP_AND_WORD, alu_pkg::OP_AND_DOUBLE, alu_pkg::OP_AND_BITFIELD,
            alu_pkg::OP_AND_STACK: decode_fn = alu_pkg::FN_AND;
            alu_pkg::OP_OR_WORD, alu_pkg::OP_OR_DOUBLE, alu_pkg::OP_OR_BITFIELD,
            alu_pkg::OP_OR_STACK: decode_fn = alu_pkg::FN_OR;
            default: decode_fn = alu_pkg::FN_XOR;
        endcase
    endfunction

    function automatic logic [31:0] apply_fn(input alu_pkg::logic_fn_t f,
                                            input logic [31:0] a,
                                            input logic [31:0] b);
        unique case (f)
            alu_pkg::FN_AND: apply_fn = a & b;
            alu_pkg::FN_OR: apply_fn = a | b;
            default: apply_fn = a ^ b;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    assign op = OP_VALID_I ? REQ_I.opcode : alu_pkg::OP_NOP;
    assign fn = decode_fn(op);
    assign is_word = (op == alu_pkg::OP_AND_WORD) || (op == alu_pkg::OP_OR_WORD)
                  || (op == alu_pkg::OP_XOR_WORD);
    assign is_bitfield = (op == alu_pkg::OP_AND_BITFIELD) || (op == alu_pkg::OP_OR_BITFIELD)
                      || (op == alu_pkg::OP_XOR_BITFIELD);
    assign is_stack = (op == alu_pkg::OP_AND_STACK) || (op == alu_pkg::OP_OR_STACK)
                   || (op == alu_pkg::OP_XOR_STACK);
    assign is_load = (op == alu_pkg::OP_LOAD_WORD);

    // A bit-field run outside 1..32 is dropped without touching state.
    assign count_ok = (REQ_I.bit_count >= 6'(alu_pkg::BIT_CNT_MIN))
                   && (REQ_I.bit_count <= 6'(alu_pkg::BIT_CNT_MAX));

    bitfield_packer u_packer (
        .bits_i(REQ_I.operand),
        .count_i(REQ_I.bit_count),
        .packed_o(field_operand)
    );

    // Word operations see only the low halves; the upper half stays clear.
    assign operand = is_word ? {16'h0000, REQ_I.operand[alu_pkg::WORD_W-1:0]}
                   : is_bitfield ? field_operand
                   : is_stack ? stack_q[0]
                   : REQ_I.operand;
    assign result = is_word ? apply_fn(fn, {16'h0000, acc_q[alu_pkg::WORD_W-1:0]}, operand)
                  : apply_fn(fn, acc_q, operand);

    assign affects_flags = (op != alu_pkg::OP_NOP) && !(is_bitfield && !count_ok);
    assign do_pop = is_stack;
    assign do_push = is_load && last_was_load_q;

    always_comb begin
        acc_d = acc_q;
        zero_d = zero_q;
        neg_d = neg_q;
        last_was_load_d = last_was_load_q;
        if (affects_flags) begin
            acc_d = is_load ? REQ_I.operand : result;
            zero_d = (acc_d == 32'h0000_0000);
            neg_d = acc_d[alu_pkg::MSB_POS];
            last_was_load_d = is_load;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            acc_q <= alu_pkg::ACC_RESET;
            zero_q <= 1'b0;
            neg_q <= 1'b0;
            done_q <= 1'b0;
            last_was_load_q <= 1'b0;
        end else begin
            acc_q <= acc_d;
            zero_q <= zero_d;
            neg_q <= neg_d;
            done_q <= OP_VALID_I;
            last_was_load_q <= last_was_load_d;
        end
    end

    // Neighbour values feeding each level, so no index leaves the array.
    logic [31:0] pop_in [alu_pkg::STACK_DEPTH];
    logic [31:0] push_in [alu_pkg::STACK_DEPTH];

    genvar i;
    generate
        for (i = 0; i < alu_pkg::STACK_DEPTH; i++) begin : g_links
            if (i == alu_pkg::STACK_DEPTH - 1) begin : g_last
                assign pop_in[i] = alu_pkg::ACC_RESET;
            end else begin : g_mid
                assign pop_in[i] = stack_q[i+1];
            end
            if (i == 0) begin : g_first
                assign push_in[i] = acc_q;
            end else begin : g_rest
                assign push_in[i] = stack_q[i-1];
            end
        end
        for (i = 0; i < alu_pkg::STACK_DEPTH; i++) begin : g_stack
            always_ff @(posedge SYS_CLK_I) begin
                if (RST_I) begin
                    stack_q[i] <= alu_pkg::ACC_RESET;
                end else if (do_pop) begin
                    stack_q[i] <= pop_in[i];
                end else if (do_push) begin
                    stack_q[i] <= push_in[i];
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    assign STATUS_O.acc = acc_q;
    assign STATUS_O.zero_result_flag = zero_q;
    assign STATUS_O.negative_result_flag = neg_q;
    assign STACK_TOP_O = stack_q[0];
    assign OP_READY_O = 1'b1;
    assign OP_DONE_O = done_q;
endmodule // accumulator_logic_unit

// file: alu_checker_assertions.sv
`timescale 1ns/1ps
module alu_checker (
    // Clock and reset.
    input wire logic SYS_CLK_I,
    input wire logic RST_I,
    // Request and state.
    input wire logic OP_VALID_I,
    input wire alu_pkg::alu_req_t REQ_I,
    input wire alu_pkg::alu_status_t STATUS_O,
    input wire logic [31:0] STACK_TOP_O
);
    default clocking cb @(posedge SYS_CLK_I); endclocking
    default disable iff (RST_I);
    logic [3:0] opc;
    logic [31:0] acc;
    logic [31:0] arg;
    assign opc = OP_VALID_I ? REQ_I.opcode : 4'h0;
    assign acc = STATUS_O.acc;
    assign arg = REQ_I.operand;
    property p_or_wd; opc == 4'h2 |=> acc == {16'h0, $past(acc[15:0] | arg[15:0])}; endproperty
    a_or_wd: assert property (p_or_wd) else $error("word or wrong");
    property p_xor_wd;
        opc == 4'h3 |=> acc == {16'h0, $past(acc[15:0] ^ arg[15:0])}
            && !STATUS_O.negative_result_flag;
    endproperty
    a_xor_wd: assert property (p_xor_wd) else $error("word xor wrong");
    property p_and_dw; opc == 4'h4 |=> acc == $past(acc & arg); endproperty
    a_and_dw: assert property (p_and_dw) else $error("double and wrong");
    property p_or_dw; opc == 4'h5 |=> acc == $past(acc | arg); endproperty
    a_or_dw: assert property (p_or_dw) else $error("double or wrong");
    property p_xor_dw; opc == 4'h6 |=> acc == $past(acc ^ arg); endproperty
    a_xor_dw: assert property (p_xor_dw) else $error("double xor wrong");
    property p_and_st; opc == 4'hA |=> acc == $past(acc & STACK_TOP_O); endproperty
    a_and_st: assert property (p_and_st) else $error("stack and wrong");
    property p_or_st; opc == 4'hB |=> acc == $past(acc | STACK_TOP_O); endproperty
    a_or_st: assert property (p_or_st) else $error("stack or wrong");
    property p_xor_st; opc == 4'hC |=> acc == $past(acc ^ STACK_TOP_O); endproperty
    a_xor_st: assert property (p_xor_st) else $error("stack xor wrong");
    property p_flags;
        $changed(acc) |-> STATUS_O.zero_result_flag == (acc == 32'h0)
            && STATUS_O.negative_result_flag == acc[31];
    endproperty
    a_flags: assert property (p_flags) else $error("flags wrong");
    property p_hold; !$past(OP_VALID_I) |-> $stable(STATUS_O); endproperty
    a_hold: assert property (p_hold) else $error("state moved while idle");
endmodule // alu_checker

bind accumulator_logic_unit alu_checker alu_checker_inst (.SYS_CLK_I(SYS_CLK_I),
    .RST_I(RST_I), .OP_VALID_I(OP_VALID_I), .REQ_I(REQ_I), .STATUS_O(STATUS_O),
    .STACK_TOP_O(STACK_TOP_O));

// file: seq_model.sv
`timescale 1ns/1ps
module seq_model (
    // Clock.
    input wire logic clk_i,
    // Request to the unit.
    output logic valid_o,
    output alu_pkg::alu_req_t req_o
);
    initial begin
        valid_o = 1'b0;
        req_o = '0;
    end
    // Holds a request over one edge, then scrambles the idle bus.
    task automatic issue(input logic [3:0] opc, input logic [31:0] val, input logic [5:0] cnt);
        @(posedge clk_i) #1;
        valid_o = 1'b1;
        req_o = {opc, val, cnt};
        @(posedge clk_i) #1;
        valid_o = 1'b0;
        req_o = ~req_o;
    endtask
endmodule // seq_model

// file: tb.sv
`timescale 1ns/1ps
module tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic vld;
    logic done;
    logic rdy;
    logic [31:0] top;
    alu_pkg::alu_req_t req;
    alu_pkg::alu_status_t st;
    int fail_count = 0;
    int total_checks = 0;
    always #10 clk = ~clk;
    seq_model seq_model_inst (.clk_i(clk), .valid_o(vld), .req_o(req));
    accumulator_logic_unit accumulator_logic_unit_inst (.SYS_CLK_I(clk), .RST_I(rst),
        .OP_VALID_I(vld), .REQ_I(req), .STATUS_O(st), .STACK_TOP_O(top), .OP_READY_O(rdy),
        .OP_DONE_O(done));
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic run(input logic [3:0] opc, input logic [31:0] val, input logic [5:0] cnt);
        seq_model_inst.issue(opc, val, cnt);
    endtask
    task automatic expect_acc(input logic [31:0] e);
        check("acc", st.acc, e);
        check("zero", {31'h0, st.zero_result_flag}, {31'h0, e == 32'h0});
        check("neg", {31'h0, st.negative_result_flag}, {31'h0, e[31]});
        check("ready", {31'h0, rdy}, 32'h1);
        check("done", {31'h0, done}, 32'h1);
    endtask
    task automatic word_ops;
        run(4'hD, 32'hFFFF1234, 6'h0);
        run(4'h2, 32'h00000F00, 6'h0);
        expect_acc(32'h00001F34);
        run(4'h3, 32'h00001F34, 6'h0);
        expect_acc(32'h0);
    endtask
    task automatic double_ops;
        run(4'hD, 32'hC0000001, 6'h0);
        run(4'h4, 32'h8FFFFFFF, 6'h0);
        expect_acc(32'h80000001);
        run(4'h5, 32'h36476A38, 6'h0);
        expect_acc(32'hB6476A39);
        run(4'h6, 32'hB6476A39, 6'h0);
        expect_acc(32'h0);
    endtask
    task automatic field_ops;
        run(4'hD, 32'hFFFFFFFF, 6'h0);
        run(4'h7, 32'hFFFFFFF5, 6'h04);
        expect_acc(32'h00000005);
        run(4'h8, 32'hFFFFFFFF, 6'h20);
        expect_acc(32'hFFFFFFFF);
        run(4'h7, 32'h0, 6'h00);
        expect_acc(32'hFFFFFFFF);
        run(4'h9, 32'h00000003, 6'h01);
        expect_acc(32'hFFFFFFFE);
    endtask
    task automatic stack_ops;
        run(4'hD, 32'h000000F0, 6'h0);
        run(4'hD, 32'h800000FF, 6'h0);
        check("top", top, 32'h000000F0);
        run(4'hD, 32'h00000F0F, 6'h0);
        run(4'hA, 32'h0, 6'h0);
        expect_acc(32'h0000000F);
        check("top", top, 32'h000000F0);
        run(4'hB, 32'h0, 6'h0);
        expect_acc(32'h000000FF);
        check("top", top, 32'h0);
        run(4'hD, 32'h00000005, 6'h0);
        run(4'hD, 32'h00000006, 6'h0);
        check("top", top, 32'h00000005);
        run(4'hC, 32'h0, 6'h0);
        expect_acc(32'h00000003);
        check("top", top, 32'h0);
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge clk);
        #1;
        rst = 1'b0;
        word_ops();
        double_ops();
        field_ops();
        stack_ops();
        report_and_stop();
    end
    initial begin
        #20000;
        fail_count++;
        report_and_stop();
    end
endmodule // tb
